// ===== slpc_pkg.sv
// constants for the serial lane phy control register bank
package slpc_pkg;
  localparam int NUM_LANES = 8;
  localparam int CODE_W = 4;
  localparam int IDX_W = 10;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_PLL_REF_CONFIG = 10'h084;
  localparam logic [9:0] IDX_IFACE_POWER = 10'h200;
  localparam logic [9:0] IDX_LANE_POWER_DOWN = 10'h201;
  localparam logic [9:0] IDX_RECOVERY_RESET = 10'h206;
  localparam logic [9:0] IDX_RECOVERY_SAMPLING = 10'h230;
  localparam logic [9:0] IDX_PLL_CONTROL = 10'h280;
  localparam logic [9:0] IDX_PLL_STATE = 10'h281;
  localparam logic [9:0] IDX_PLL_DIVIDER = 10'h289;
  localparam logic [9:0] IDX_TERM_CAL_CTRL_A = 10'h2a7;
  localparam logic [9:0] IDX_TERM_OVERRIDE_A = 10'h2a8;
  localparam logic [9:0] IDX_TERM_CAL_CODE_A = 10'h2ac;
  localparam logic [9:0] IDX_TERM_CAL_CTRL_B = 10'h2ae;
  localparam logic [9:0] IDX_TERM_OVERRIDE_B = 10'h2af;
  localparam logic [9:0] IDX_TERM_CAL_CODE_B = 10'h2b3;
  localparam logic [9:0] IDX_TERM_OFFSET_FIRST = 10'h2bb;
  localparam logic [9:0] IDX_TERM_OFFSET_LAST = 10'h2c2;
  localparam logic [9:0] IDX_LINK_INFO = 10'h2d0;
  localparam logic [9:0] IDX_FRAME_CONFIG = 10'h2d1;
  // field positions
  localparam int BIT_IFACE_PD = 0;
  localparam int BIT_CAL_START = 0;
  localparam int BIT_OVERRIDE_EN = 4;
  localparam int OVR_VAL_HI = 3;
  localparam int OVR_VAL_LO = 1;
  localparam int BIT_OFFSET_SIGN = 3;
  localparam int BIT_PLL_ENABLE = 0;
  localparam int BIT_PLL_RECAL = 2;
  localparam int BIT_PLL_LOCK = 0;
  localparam int BIT_PLL_CAL_DONE = 3;
  localparam int BIT_PLL_BAND_LOW = 4;
  localparam int BIT_PLL_BAND_HIGH = 5;
  localparam int REF_MULT_HI = 5;
  localparam int REF_MULT_LO = 4;
  localparam int REF_DIV_HI = 1;
  localparam int REF_DIV_LO = 0;
  localparam int BIT_HALF_RATE = 5;
  localparam int REC_DIV_HI = 2;
  localparam int REC_DIV_LO = 1;
  localparam int BIT_RECOVERY_RUN = 0;
  localparam int FRAME_F_HI = 2;
  localparam int FRAME_FPP_LO = 4;
  // lane groups of the two termination calibration blocks
  localparam logic [7:0] GROUP_A_LANES = 8'hc3;
  // reset values
  localparam logic [7:0] RST_IFACE_POWER = 8'h01;
  localparam logic [7:0] RST_LANE_POWER_DOWN = 8'hff;
  localparam logic [7:0] RST_FRAME_CONFIG = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // rate relationships
  localparam logic [7:0] DEMUX_WIDTH = 8'h28;
  localparam logic [2:0] BYTES_PER_PCLK = 3'h4;
  localparam int BITS_PER_SYMBOL = 10;
  localparam int REF_CLOCK_RATIO = 40;
  localparam int PFD_MIN_MHZ = 35;
  localparam int PFD_MAX_MHZ = 80;
endpackage : slpc_pkg

// ===== slpc_term_lane.sv
// per-lane termination setting: autocal code, override and signed offset
`timescale 1ns/100ps
`default_nettype none
module slpc_term_lane
  import slpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] auto_code,
  input wire logic override_en,
  input wire logic [2:0] override_val,
  input wire logic [3:0] offset,
  output logic [3:0] code
);
  logic [4:0] up_sum;
  logic [4:0] down_diff;
  logic [3:0] next_code;

  assign up_sum = {1'b0, auto_code} + {2'b00, offset[2:0]};
  assign down_diff = {1'b0, auto_code} - {2'b00, offset[2:0]};

  always_comb begin
    if (override_en) begin
      next_code = {override_val, 1'b0};
    end else if (offset[BIT_OFFSET_SIGN]) begin
      next_code = down_diff[4] ? 4'h0 : down_diff[3:0];
    end else begin
      next_code = up_sum[4] ? 4'hf : up_sum[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      code <= 4'h0;
    end else begin
      code <= next_code;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_override_value;
    override_en |=> code == {$past(override_val), 1'b0};
  endproperty
  a_override_value: assert property (p_override_value) else $error("override value not applied");

  property p_offset_signed;
    !override_en && offset[BIT_OFFSET_SIGN] && auto_code >= {1'b0, offset[2:0]}
      |=> code == $past(auto_code) - {1'b0, $past(offset[2:0])};
  endproperty
  a_offset_signed: assert property (p_offset_signed) else $error("negative offset wrong");
endmodule : slpc_term_lane
`default_nettype wire

// ===== slpc_phy_ctrl.sv
// serial lane phy control register bank on classic wishbone
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module slpc_phy_ctrl
  import slpc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [11:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  output logic IFACE_PD,
  output logic [7:0] LANE_PD,
  output logic TERM_CAL_START_A,
  output logic TERM_CAL_START_B,
  output logic [31:0] TERM_SETTING,
  output logic PLL_ENABLE,
  output logic PLL_RECAL,
  output logic [1:0] PLL_REF_MULT,
  output logic [1:0] LANE_PLL_REF_DIVIDER,
  output logic RECOVERY_HALF_RATE_SELECT,
  output logic [1:0] RECOVERY_RATE_DIVIDER,
  output logic RECOVERY_RST_N,
  input wire logic PLL_LOCK,
  input wire logic PLL_CAL_DONE,
  input wire logic PLL_BAND_LOW,
  input wire logic PLL_BAND_HIGH,
  input wire logic [3:0] TERM_CODE_A,
  input wire logic [3:0] TERM_CODE_B
);
  logic [9:0] idx;
  logic take;
  logic wr;
  logic rd;
  logic [7:0] next_dat;

  logic [7:0] lane_pll_ref_config;
  logic [7:0] serial_iface_power;
  logic [7:0] lane_power_down;
  logic [7:0] recovery_reset;
  logic [7:0] recovery_sampling_config;
  logic [7:0] lane_pll_control;
  logic [7:0] lane_pll_divider;
  logic [7:0] term_cal_ctrl_group_a;
  logic [7:0] term_cal_ctrl_group_b;
  logic [7:0] term_override_group_a;
  logic [7:0] term_override_group_b;
  logic [7:0] term_offset [NUM_LANES];
  logic [7:0] frame_config;

  logic cal_a_prev;
  logic cal_b_prev;
  logic recal_prev;
  logic [11:0] status_meta;
  logic [11:0] status_sync;
  logic pll_lock;
  logic pll_cal_done;
  logic pll_band_low;
  logic pll_band_high;
  logic [3:0] code_a;
  logic [3:0] code_b;

  // frames carried per processing clock for a given octets-per-frame
  function automatic logic [2:0] frames_per_pclk(input logic [2:0] f);
    case (f)
      3'h1: frames_per_pclk = BYTES_PER_PCLK;
      3'h2: frames_per_pclk = BYTES_PER_PCLK >> 1;
      3'h4: frames_per_pclk = BYTES_PER_PCLK >> 2;
      default: frames_per_pclk = 3'h0;
    endcase
  endfunction : frames_per_pclk

  assign idx = ADR_I[11:2];
  // a request is taken once; ack blocks the repeat cycle
  assign take = CYC_I & STB_I & ~ACK_O;
  assign wr = take & WE_I & SEL_I[0];
  assign rd = take & ~WE_I;

  // slow analog status crosses in through two flops; the code
  // bits are quasi-static once calibration is done
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      status_meta <= 12'h000;
      status_sync <= 12'h000;
    end else begin
      status_meta <= {TERM_CODE_B, TERM_CODE_A, PLL_BAND_HIGH, PLL_BAND_LOW, PLL_CAL_DONE, PLL_LOCK};
      status_sync <= status_meta;
    end
  end

  assign pll_lock = status_sync[0];
  assign pll_cal_done = status_sync[1];
  assign pll_band_low = status_sync[2];
  assign pll_band_high = status_sync[3];
  assign code_a = status_sync[7:4];
  assign code_b = status_sync[11:8];

  // register writes; status registers ignore writes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      lane_pll_ref_config <= RST_ZERO;
      serial_iface_power <= RST_IFACE_POWER;
      lane_power_down <= RST_LANE_POWER_DOWN;
      recovery_reset <= RST_ZERO;
      recovery_sampling_config <= RST_ZERO;
      lane_pll_control <= RST_ZERO;
      lane_pll_divider <= RST_ZERO;
      term_cal_ctrl_group_a <= RST_ZERO;
      term_cal_ctrl_group_b <= RST_ZERO;
      term_override_group_a <= RST_ZERO;
      term_override_group_b <= RST_ZERO;
      frame_config <= RST_FRAME_CONFIG;
      for (int i = 0; i < NUM_LANES; i++) begin
        term_offset[i] <= RST_ZERO;
      end
    end else if (wr) begin
      case (idx)
        IDX_PLL_REF_CONFIG: lane_pll_ref_config <= DAT_I[7:0];
        IDX_IFACE_POWER: serial_iface_power <= DAT_I[7:0];
        IDX_LANE_POWER_DOWN: lane_power_down <= DAT_I[7:0];
        IDX_RECOVERY_RESET: recovery_reset <= DAT_I[7:0];
        IDX_RECOVERY_SAMPLING: recovery_sampling_config <= DAT_I[7:0];
        IDX_PLL_CONTROL: lane_pll_control <= DAT_I[7:0];
        IDX_PLL_DIVIDER: lane_pll_divider <= DAT_I[7:0];
        IDX_TERM_CAL_CTRL_A: term_cal_ctrl_group_a <= DAT_I[7:0];
        IDX_TERM_CAL_CTRL_B: term_cal_ctrl_group_b <= DAT_I[7:0];
        IDX_TERM_OVERRIDE_A: term_override_group_a <= DAT_I[7:0];
        IDX_TERM_OVERRIDE_B: term_override_group_b <= DAT_I[7:0];
        IDX_FRAME_CONFIG: frame_config <= {5'h00, DAT_I[FRAME_F_HI:0]};
        default: begin
          for (int i = 0; i < NUM_LANES; i++) begin
            if (idx == IDX_TERM_OFFSET_FIRST + 10'(i)) begin
              term_offset[i] <= DAT_I[7:0];
            end
          end
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    next_dat = 8'h00;
    case (idx)
      IDX_PLL_REF_CONFIG: next_dat = lane_pll_ref_config;
      IDX_IFACE_POWER: next_dat = serial_iface_power;
      IDX_LANE_POWER_DOWN: next_dat = lane_power_down;
      IDX_RECOVERY_RESET: next_dat = recovery_reset;
      IDX_RECOVERY_SAMPLING: next_dat = recovery_sampling_config;
      IDX_PLL_CONTROL: next_dat = lane_pll_control;
      IDX_PLL_DIVIDER: next_dat = lane_pll_divider;
      IDX_TERM_CAL_CTRL_A: next_dat = term_cal_ctrl_group_a;
      IDX_TERM_CAL_CTRL_B: next_dat = term_cal_ctrl_group_b;
      IDX_TERM_OVERRIDE_A: next_dat = term_override_group_a;
      IDX_TERM_OVERRIDE_B: next_dat = term_override_group_b;
      IDX_PLL_STATE: begin
        next_dat[BIT_PLL_LOCK] = pll_lock;
        next_dat[BIT_PLL_CAL_DONE] = pll_cal_done;
        next_dat[BIT_PLL_BAND_LOW] = pll_band_low;
        next_dat[BIT_PLL_BAND_HIGH] = pll_band_high;
      end
      IDX_TERM_CAL_CODE_A: next_dat = {4'h0, code_a};
      IDX_TERM_CAL_CODE_B: next_dat = {4'h0, code_b};
      IDX_LINK_INFO: next_dat = DEMUX_WIDTH;
      IDX_FRAME_CONFIG: next_dat = {1'b0, frames_per_pclk(frame_config[FRAME_F_HI:0]), frame_config[3:0]};
      default: begin
        for (int i = 0; i < NUM_LANES; i++) begin
          if (idx == IDX_TERM_OFFSET_FIRST + 10'(i)) begin
            next_dat = term_offset[i];
          end
        end
      end
    endcase
  end

  // answer one cycle after the request, unmapped reads give zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= take;
      DAT_O <= rd ? {24'h00_0000, next_dat} : 32'h0000_0000;
    end
  end

  // power controls to the lanes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IFACE_PD <= 1'b1;
      LANE_PD <= RST_LANE_POWER_DOWN;
    end else begin
      // powered up only when bit0 clear
      IFACE_PD <= serial_iface_power[BIT_IFACE_PD];
      LANE_PD <= lane_power_down;
    end
  end

  // calibration start pulses; rewriting 0x01 over 0x01 gives no edge
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cal_a_prev <= 1'b0;
      cal_b_prev <= 1'b0;
      TERM_CAL_START_A <= 1'b0;
      TERM_CAL_START_B <= 1'b0;
    end else begin
      cal_a_prev <= term_cal_ctrl_group_a[BIT_CAL_START];
      cal_b_prev <= term_cal_ctrl_group_b[BIT_CAL_START];
      TERM_CAL_START_A <= term_cal_ctrl_group_a[BIT_CAL_START] & ~cal_a_prev;
      TERM_CAL_START_B <= term_cal_ctrl_group_b[BIT_CAL_START] & ~cal_b_prev;
    end
  end

  // pll and clock recovery controls
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      recal_prev <= 1'b0;
      PLL_ENABLE <= 1'b0;
      PLL_RECAL <= 1'b0;
      PLL_REF_MULT <= 2'b00;
      LANE_PLL_REF_DIVIDER <= 2'b00;
      RECOVERY_HALF_RATE_SELECT <= 1'b0;
      RECOVERY_RATE_DIVIDER <= 2'b00;
      RECOVERY_RST_N <= 1'b0;
    end else begin
      recal_prev <= lane_pll_control[BIT_PLL_RECAL];
      PLL_ENABLE <= lane_pll_control[BIT_PLL_ENABLE];
      PLL_RECAL <= lane_pll_control[BIT_PLL_RECAL] & ~recal_prev;
      PLL_REF_MULT <= lane_pll_ref_config[REF_MULT_HI:REF_MULT_LO];
      LANE_PLL_REF_DIVIDER <= lane_pll_divider[REF_DIV_HI:REF_DIV_LO];
      RECOVERY_HALF_RATE_SELECT <= recovery_sampling_config[BIT_HALF_RATE];
      RECOVERY_RATE_DIVIDER <= recovery_sampling_config[REC_DIV_HI:REC_DIV_LO];
      // recovery held in reset while bit0 clear
      RECOVERY_RST_N <= recovery_reset[BIT_RECOVERY_RUN];
    end
  end

  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    localparam bit IN_A = GROUP_A_LANES[g];
    slpc_term_lane u_term (
      .clk(SYS_CLK),
      .rst(RST),
      .auto_code(IN_A ? code_a : code_b),
      .override_en(IN_A ? term_override_group_a[BIT_OVERRIDE_EN] : term_override_group_b[BIT_OVERRIDE_EN]),
      .override_val(IN_A ? term_override_group_a[OVR_VAL_HI:OVR_VAL_LO]
                         : term_override_group_b[OVR_VAL_HI:OVR_VAL_LO]),
      .offset(term_offset[g][3:0]),
      .code(TERM_SETTING[g*CODE_W +: CODE_W])
    );
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  property p_iface_power;
    wr && idx == IDX_IFACE_POWER |-> ##2 IFACE_PD == $past(DAT_I[BIT_IFACE_PD], 2);
  endproperty
  a_iface_power: assert property (p_iface_power) else $error("interface power not applied");

  property p_lane_power;
    wr && idx == IDX_LANE_POWER_DOWN |-> ##2 LANE_PD == $past(DAT_I[7:0], 2);
  endproperty
  a_lane_power: assert property (p_lane_power) else $error("lane power-down not applied");

  property p_cal_start_a;
    wr && idx == IDX_TERM_CAL_CTRL_A && DAT_I[0] && !term_cal_ctrl_group_a[0]
      |-> ##2 TERM_CAL_START_A ##1 !TERM_CAL_START_A;
  endproperty
  a_cal_start_a: assert property (p_cal_start_a) else $error("group a start missing");

  // lane 1 belongs to group a, lane 5 to group b
  property p_group_map;
    !term_override_group_a[BIT_OVERRIDE_EN] && !term_override_group_b[BIT_OVERRIDE_EN]
      && term_offset[1][3:0] == 4'h0 && term_offset[5][3:0] == 4'h0
      |=> TERM_SETTING[7:4] == $past(code_a) && TERM_SETTING[23:20] == $past(code_b);
  endproperty
  a_group_map: assert property (p_group_map) else $error("lane group mapping wrong");

  property p_code_read;
    rd && idx == IDX_TERM_CAL_CODE_A |=> ACK_O && DAT_O[3:0] == $past(code_a) && DAT_O[7:4] == 4'h0;
  endproperty
  a_code_read: assert property (p_code_read) else $error("code a readback wrong");

  property p_recal;
    $rose(lane_pll_control[BIT_PLL_RECAL]) |=> PLL_RECAL ##1 !PLL_RECAL;
  endproperty
  a_recal: assert property (p_recal) else $error("recal pulse wrong");

  property p_pll_state;
    rd && idx == IDX_PLL_STATE |=> DAT_O[BIT_PLL_LOCK] == $past(pll_lock)
      && DAT_O[BIT_PLL_BAND_HIGH] == $past(pll_band_high);
  endproperty
  a_pll_state: assert property (p_pll_state) else $error("pll state readback wrong");

  property p_state_readonly;
    wr && (idx == IDX_PLL_STATE || idx == IDX_TERM_CAL_CODE_A || idx == IDX_TERM_CAL_CODE_B)
      |=> $stable(lane_pll_control) && $stable(term_cal_ctrl_group_a) && $stable(term_cal_ctrl_group_b);
  endproperty
  a_state_readonly: assert property (p_state_readonly) else $error("status write disturbed control");

  property p_frames;
    rd && idx == IDX_FRAME_CONFIG && frame_config[2:0] == 3'h2 |=> DAT_O[6:4] == 3'h2;
  endproperty
  a_frames: assert property (p_frames) else $error("frames per cycle wrong");

  property p_ack_one;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");

  property p_divider;
    wr && idx == IDX_PLL_DIVIDER |-> ##2 LANE_PLL_REF_DIVIDER == $past(DAT_I[1:0], 2);
  endproperty
  a_divider: assert property (p_divider) else $error("divider not applied");

  c_write: cover property (wr && idx == IDX_LANE_POWER_DOWN);
  c_read_state: cover property (rd && idx == IDX_PLL_STATE);
  c_cal_start: cover property (TERM_CAL_START_A ##[1:50] TERM_CAL_START_B);
  c_recal: cover property (PLL_ENABLE && PLL_RECAL);
endmodule : slpc_phy_ctrl
`default_nettype wire

// ===== slpc_phy_model.sv
// behavioural model of the analog lane phy behind the control bank
`timescale 1ns/100ps
`default_nettype none
module slpc_phy_model #(
  parameter int CAL_CYCLES = 20,
  parameter logic [3:0] CODE_A = 4'h7,
  parameter logic [3:0] CODE_B = 4'h6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pll_enable,
  input wire logic pll_recal,
  input wire logic cal_start_a,
  input wire logic cal_start_b,
  input wire logic [1:0] band_req,
  output logic pll_lock,
  output logic pll_cal_done,
  output logic pll_band_low,
  output logic pll_band_high,
  output logic [3:0] code_a,
  output logic [3:0] code_b
);
  int pll_cnt;
  int cnt_a;
  int cnt_b;
  // lock after a delay, recal drops lock first
  always_ff @(posedge clk) begin
    if (rst || !pll_enable || pll_recal) begin
      pll_cnt <= 0;
    end else if (pll_cnt < CAL_CYCLES) begin
      pll_cnt <= pll_cnt + 1;
    end
  end
  assign pll_lock = (pll_cnt == CAL_CYCLES);
  assign pll_cal_done = (pll_cnt == CAL_CYCLES);
  // band limits only when a scenario asks for them
  assign pll_band_low = band_req[0];
  assign pll_band_high = band_req[1];
  // each group calibrates on its own start, code unknown meanwhile reads 0
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_a <= 0;
      cnt_b <= 0;
      code_a <= 4'h0;
      code_b <= 4'h0;
    end else begin
      cnt_a <= cal_start_a ? 1 : (cnt_a == 0 || cnt_a == CAL_CYCLES) ? 0 : cnt_a + 1;
      cnt_b <= cal_start_b ? 1 : (cnt_b == 0 || cnt_b == CAL_CYCLES) ? 0 : cnt_b + 1;
      code_a <= cal_start_a ? 4'h0 : (cnt_a == CAL_CYCLES) ? CODE_A : code_a;
      code_b <= cal_start_b ? 4'h0 : (cnt_b == CAL_CYCLES) ? CODE_B : code_b;
    end
  end
endmodule : slpc_phy_model
`default_nettype wire

// ===== slpc_phy_ctrl_tb.sv
// self-checking bench for the lane phy control bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module slpc_phy_ctrl_tb
  import slpc_pkg::*;
;
  localparam logic [3:0] CA = 4'h7;
  localparam logic [3:0] CB = 4'h6;
  logic sys_clk, rst, we, cyc, stb, ack, iface_pd, start_a, start_b, pll_en, pll_recal;
  logic half_rate, rec_rst_n, lock, cal_done, band_low, band_high;
  logic [11:0] adr;
  logic [31:0] dat_w, dat_r, term, exp_term;
  logic [3:0] sel, code_a, code_b;
  logic [7:0] lane_pd, q;
  logic [1:0] ref_mult, ref_div, rec_div, band_req;
  logic [1:0] mult [4] = '{2'b01, 2'b00, 2'b00, 2'b00};
  logic [1:0] pdiv [4] = '{2'b10, 2'b10, 2'b01, 2'b00};
  logic [1:0] rdiv [4] = '{2'b10, 2'b01, 2'b00, 2'b00};
  int errors, checks_done, n_start_a, n_start_b, n_recal, i, f;

  slpc_phy_ctrl slpc_phy_ctrl_inst (.SYS_CLK(sys_clk), .RST(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r),
    .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .IFACE_PD(iface_pd), .LANE_PD(lane_pd),
    .TERM_CAL_START_A(start_a), .TERM_CAL_START_B(start_b), .TERM_SETTING(term), .PLL_ENABLE(pll_en),
    .PLL_RECAL(pll_recal), .PLL_REF_MULT(ref_mult), .LANE_PLL_REF_DIVIDER(ref_div),
    .RECOVERY_HALF_RATE_SELECT(half_rate), .RECOVERY_RATE_DIVIDER(rec_div), .RECOVERY_RST_N(rec_rst_n),
    .PLL_LOCK(lock), .PLL_CAL_DONE(cal_done), .PLL_BAND_LOW(band_low), .PLL_BAND_HIGH(band_high),
    .TERM_CODE_A(code_a), .TERM_CODE_B(code_b));
  slpc_phy_model #(.CAL_CYCLES(20), .CODE_A(CA), .CODE_B(CB)) slpc_phy_model_inst (.clk(sys_clk), .rst(rst),
    .pll_enable(pll_en), .pll_recal(pll_recal), .cal_start_a(start_a), .cal_start_b(start_b),
    .band_req(band_req), .pll_lock(lock), .pll_cal_done(cal_done), .pll_band_low(band_low),
    .pll_band_high(band_high), .code_a(code_a), .code_b(code_b));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // one-cycle pulses are counted where they stand
  always @(posedge sys_clk) begin
    if (start_a === 1'b1) n_start_a++;
    if (start_b === 1'b1) n_start_b++;
    if (pll_recal === 1'b1) n_recal++;
  end

  task automatic wb_cycle(input logic [9:0] idx, input logic wr, input logic [7:0] d, input logic [3:0] s);
    adr <= {idx, 2'b00};
    dat_w <= {24'h000000, d};
    we <= wr;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    // no cycle limit here; the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge sys_clk);
  endtask : wb_cycle

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    wb_cycle(idx, 1'b1, d, 4'h1);
  endtask : wr

  // status may lag, so poll a bounded number of times then compare
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e, input int tries = 1);
    int k;
    k = 0;
    do begin
      wb_cycle(idx, 1'b0, 8'h00, 4'h1);
      k++;
    end while (q !== e && k < tries);
    `CHK(q, e)
  endtask : rd_chk

  function automatic logic [31:0] term_exp(input logic [3:0] a, input logic [3:0] b);
    int j;
    term_exp = 32'h00000000;
    for (j = 0; j < 8; j++) term_exp[4*j +: 4] = (8'hc3 >> j) & 8'h01 ? a : b;
  endfunction : term_exp

  task automatic report_and_stop;
    $display("%0d checks made, %0d errors", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end

  initial begin
    {rst, we, cyc, stb, sel, adr, dat_w, band_req} = {1'b1, 3'b000, 4'h0, 12'h000, 32'h0, 2'b00};
    {errors, checks_done, n_start_a, n_start_b, n_recal} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK({iface_pd, lane_pd}, 9'h1ff)
    rd_chk(IDX_IFACE_POWER, 8'h01);
    rd_chk(IDX_LANE_POWER_DOWN, 8'hff);
    rd_chk(IDX_LINK_INFO, 8'h28);
    rd_chk(10'h3ff, 8'h00);
    $display("test reset done");
    wr(IDX_IFACE_POWER, 8'h00);
    `CHK(iface_pd, 1'b0)
    wr(IDX_LANE_POWER_DOWN, 8'ha5);
    wb_cycle(IDX_LANE_POWER_DOWN, 1'b1, 8'h00, 4'h0);
    `CHK(lane_pd, 8'ha5)
    $display("test power done");
    wr(IDX_PLL_DIVIDER, 8'h01);
    wr(IDX_PLL_CONTROL, 8'h01);
    `CHK(pll_en, 1'b1)
    rd_chk(IDX_PLL_STATE, 8'h09, 60);
    wr(IDX_PLL_CONTROL, 8'h05);
    wr(IDX_PLL_CONTROL, 8'h05);
    wr(IDX_PLL_CONTROL, 8'h01);
    wr(IDX_PLL_CONTROL, 8'h05);
    rd_chk(IDX_PLL_STATE, 8'h00, 10);
    rd_chk(IDX_PLL_STATE, 8'h09, 60);
    `CHK(n_recal, 2)
    wr(IDX_PLL_STATE, 8'hf0);
    band_req <= 2'b11;
    rd_chk(IDX_PLL_STATE, 8'h39, 5);
    band_req <= 2'b00;
    $display("test pll done");
    wr(IDX_TERM_OFFSET_FIRST, 8'h01);
    wr(IDX_TERM_CAL_CTRL_A, 8'h01);
    rd_chk(IDX_TERM_CAL_CODE_A, {4'h0, CA}, 60);
    `CHK({n_start_a, n_start_b}, {32'd1, 32'd0})
    wr(IDX_TERM_CAL_CTRL_B, 8'h01);
    wr(IDX_TERM_CAL_CTRL_B, 8'h01);
    rd_chk(IDX_TERM_CAL_CODE_B, {4'h0, CB}, 60);
    `CHK(n_start_b, 1)
    exp_term = term_exp(CA, CB);
    exp_term[3:0] = CA + 4'h1;
    `CHK(term, exp_term)
    wr(IDX_TERM_OVERRIDE_A, 8'h1a);
    `CHK(term, term_exp(4'ha, CB))
    wr(IDX_TERM_OVERRIDE_A, 8'h0a);
    `CHK(term, exp_term)
    wr(IDX_TERM_OFFSET_FIRST + 10'h002, 8'h03);
    wr(IDX_TERM_OFFSET_FIRST + 10'h003, 8'h09);
    wr(IDX_TERM_OFFSET_FIRST + 10'h004, 8'h0f);
    exp_term[19:8] = {4'h0, CB - 4'h1, CB + 4'h3};
    `CHK(term, exp_term)
    rd_chk(IDX_TERM_OFFSET_FIRST + 10'h004, 8'h0f);
    $display("test termination done");
    for (i = 0; i < 4; i++) begin
      wr(IDX_PLL_REF_CONFIG, {2'b00, mult[i], 4'h0});
      wr(IDX_PLL_DIVIDER, {6'h00, pdiv[i]});
      wr(IDX_RECOVERY_SAMPLING, {2'b00, 1'(i == 3), 2'b00, rdiv[i], 1'b0});
      `CHK({ref_mult, ref_div}, {mult[i], pdiv[i]})
      `CHK({half_rate, rec_div}, {1'(i == 3), rdiv[i]})
    end
    wr(IDX_RECOVERY_RESET, 8'h00);
    `CHK(rec_rst_n, 1'b0)
    wr(IDX_RECOVERY_RESET, 8'h01);
    `CHK(rec_rst_n, 1'b1)
    $display("test rates done");
    for (f = 1; f <= 4; f = f * 2) begin
      wr(IDX_FRAME_CONFIG, 8'(f));
      rd_chk(IDX_FRAME_CONFIG, {1'b0, 3'(4 / f), 1'b0, 3'(f)});
    end
    wr(IDX_FRAME_CONFIG, 8'h03);
    rd_chk(IDX_FRAME_CONFIG, 8'h03);
    $display("test frame done");
    report_and_stop();
  end
endmodule : slpc_phy_ctrl_tb
`undef CHK
`default_nettype wire
